/* rtl/isg_target.sv */
// I2C target engine with clock stretching, general call and address mask
`include "isg_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module isg_target (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic SCL_LINK,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic PORT_ENABLE,
    input wire logic [3:0] PORT_MODE_SELECT,
    input wire logic STRETCH_ENABLE,
    input wire logic ADDRESS_HOLD_ENABLE,
    input wire logic DATA_HOLD_ENABLE,
    input wire logic GENERAL_CALL_ENABLE,
    input wire logic ACK_VALUE_TO_SEND,
    input wire logic OWN_ADDRESS_WR,
    input wire logic [7:0] OWN_ADDRESS_DATA,
    input wire logic ADDRESS_MASK_WR,
    input wire logic [7:0] ADDRESS_MASK_DATA,
    input wire logic STRETCH_RELEASE_SET,
    input wire logic STRETCH_RELEASE_CLEAR,
    input wire logic BUF_WR,
    input wire logic [7:0] BUF_WDATA,
    input wire logic BUF_RD,
    input wire logic IRQ_CLEAR,
    input wire logic WRITE_COLLISION_FLAG_CLEAR,
    input wire logic START_REQUEST,
    input wire logic STOP_REQUEST,
    input wire logic RESTART_REQUEST,
    input wire logic FW_SCL_LOW,
    input wire logic FW_SDA_LOW,
    output logic STRETCH_RELEASE_CTL,
    output logic ADDRESS_UPDATE_FLAG,
    output logic BUFFER_FULL_FLAG,
    output logic SERIAL_PORT_IRQ_FLAG,
    output logic WRITE_COLLISION_FLAG,
    output logic [7:0] TRANSFER_BUFFER,
    output logic ACK_STATUS,
    output logic READ_NOT_WRITE,
    output logic START_SEEN,
    output logic STOP_SEEN
);
    // ****************************************************
    // Declarations
    // ****************************************************
    logic [8:0] link_shift;
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    isg_pkg::isg_ev_t ev;
    isg_pkg::isg_state_t state;
    logic [3:0] bit_cnt;
    logic ten_lo, ten_done;
    logic addr_hit, addr_rw, addr_gc, ack_hold;
    logic stretch_release_ctl, ua, bf, irq, write_collision_flag, ack_stat;
    logic s_flag, p_flag;
    logic [7:0] own_addr, mask, buffer;
    logic scl_low, sda_low, pin_level;
    logic [2:0] req_d;
    logic tgt, ten, ctl, fw;
    logic [7:0] rx_byte;
    logic m7, mlo, mhi, gcall, addr_ok;
    logic fall8, fall9, acked;
    logic ua_set, tx_go, rx_go, hold8, hw_clr;
    logic byte_ev, irq_ev, write_collision_flag_hit, req_done, tx_bit;
    // ****************************************************
    // Link domain: serial capture on the bus clock
    // ****************************************************
    // Each bit is taken on its own SCL rise; the word stays still until
    // the next rise, which the system side reads after a synced fall.
    always_ff @(posedge SCL_LINK or negedge RSTN) begin
        if (!RSTN) begin
            link_shift <= 9'h000;
        end else begin
            link_shift <= {link_shift[7:0], SDA_IN};
        end
    end
    // ****************************************************
    // Pin synchronisers and bus events
    // ****************************************************
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= SCL_IN;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= SDA_IN;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end
    always_comb begin
        ev.start = scl_s && scl_d && sda_d && !sda_s;
        ev.stop = scl_s && scl_d && !sda_d && sda_s;
        ev.rise = scl_s && !scl_d;
        ev.fall = !scl_s && scl_d;
    end
    // ****************************************************
    // Mode decode and address compare
    // ****************************************************
    always_comb begin
        tgt = PORT_ENABLE && (PORT_MODE_SELECT == `ISG_MODE_TGT7
            || PORT_MODE_SELECT == `ISG_MODE_TGT10);
        ten = PORT_MODE_SELECT == `ISG_MODE_TGT10;
        ctl = PORT_ENABLE && PORT_MODE_SELECT == `ISG_MODE_CTRL;
        fw = PORT_ENABLE && PORT_MODE_SELECT == `ISG_MODE_FWCTRL;
        rx_byte = link_shift[7:0];
        m7 = ((rx_byte[7:1] ^ own_addr[7:1]) & mask[7:1]) == 7'h00;
        mlo = ((rx_byte ^ own_addr) & mask) == 8'h00;
        // High byte of a ten-bit address is never masked
        mhi = rx_byte[7:3] == `ISG_TEN_PFX
            && rx_byte[2:1] == own_addr[2:1];
        gcall = GENERAL_CALL_ENABLE && rx_byte == `ISG_GCALL_ADDR
            && !ten_lo;
        if (ten) begin
            addr_ok = gcall || (ten_lo ? mlo
                : (mhi && (!rx_byte[0] || ten_done)));
        end else begin
            addr_ok = gcall || m7;
        end
    end
    // ****************************************************
    // Frame events
    // ****************************************************
    always_comb begin
        fall8 = ev.fall && bit_cnt == `ISG_BIT_ACK;
        fall9 = ev.fall && bit_cnt == `ISG_BIT_END;
        acked = !link_shift[0] && (state != isg_pkg::ST_ADDR || addr_hit);
        ua_set = fall9 && state == isg_pkg::ST_ADDR && acked && ten
            && !addr_gc && !addr_rw;
        tx_go = fall9 && acked && (state == isg_pkg::ST_TX
            || (state == isg_pkg::ST_ADDR && addr_rw));
        rx_go = fall9 && acked && !ua_set && !tx_go
            && (state == isg_pkg::ST_RX || state == isg_pkg::ST_ADDR);
        hold8 = fall8 && ((state == isg_pkg::ST_ADDR && addr_ok
            && ADDRESS_HOLD_ENABLE)
            || (state == isg_pkg::ST_RX && DATA_HOLD_ENABLE));
        // Buffer-full plays no part in any clear of stretch-release
        hw_clr = hold8 || tx_go || (rx_go && STRETCH_ENABLE);
        byte_ev = fall8 && ((state == isg_pkg::ST_ADDR && addr_ok)
            || state == isg_pkg::ST_RX);
        req_done = |(req_d & ~{START_REQUEST, STOP_REQUEST,
            RESTART_REQUEST});
        irq_ev = hold8 || (fall9 && (state == isg_pkg::ST_TX
            || ((state == isg_pkg::ST_ADDR || state == isg_pkg::ST_RX)
            && acked)))
            || (ctl && req_done)
            || (fw && (ev.start || ev.stop));
        write_collision_flag_hit = BUF_WR && ((ctl && (START_REQUEST || STOP_REQUEST
            || RESTART_REQUEST)) || (state == isg_pkg::ST_TX
            && bit_cnt != 4'h0 && bit_cnt < `ISG_BIT_ACK));
        tx_bit = buffer[~bit_cnt[2:0]];
    end
    // ****************************************************
    // Target sequencer
    // ****************************************************
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state <= isg_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            ten_lo <= 1'b0;
            ten_done <= 1'b0;
        end else if (!tgt || ev.stop) begin
            state <= isg_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            ten_lo <= 1'b0;
            ten_done <= 1'b0;
        end else if (ev.start) begin
            state <= isg_pkg::ST_ADDR;
            bit_cnt <= 4'h0;
            ten_lo <= 1'b0;
        end else if (fall9) begin
            bit_cnt <= 4'h0;
            unique case (state)
                isg_pkg::ST_IDLE: begin
                    state <= isg_pkg::ST_IDLE;
                end
                isg_pkg::ST_ADDR, isg_pkg::ST_RX, isg_pkg::ST_TX: begin
                    if (ua_set && !ten_lo) begin
                        state <= isg_pkg::ST_ADDR;
                        ten_lo <= 1'b1;
                    end else if (ua_set) begin
                        state <= isg_pkg::ST_RX;
                        ten_lo <= 1'b0;
                        ten_done <= 1'b1;
                    end else if (tx_go) begin
                        state <= isg_pkg::ST_TX;
                    end else if (rx_go) begin
                        state <= isg_pkg::ST_RX;
                    end else begin
                        state <= isg_pkg::ST_SKIP;
                    end
                end
                isg_pkg::ST_SKIP: begin
                    state <= isg_pkg::ST_SKIP;
                end
                default: begin
                    state <= isg_pkg::ST_IDLE;
                end
            endcase
        end else if (ev.rise && bit_cnt < `ISG_BIT_END) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            addr_hit <= 1'b0;
            addr_rw <= 1'b0;
            addr_gc <= 1'b0;
            ack_hold <= 1'b0;
        end else if (fall8 && state == isg_pkg::ST_ADDR) begin
            addr_hit <= addr_ok;
            addr_rw <= rx_byte[0] && !(ten && ten_lo);
            addr_gc <= gcall;
            ack_hold <= ADDRESS_HOLD_ENABLE;
        end else if (fall8 && state == isg_pkg::ST_RX) begin
            ack_hold <= DATA_HOLD_ENABLE;
        end
    end
    // ****************************************************
    // Software owned settings
    // ****************************************************
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            own_addr <= `ISG_OWN_RST;
        end else if (OWN_ADDRESS_WR) begin
            own_addr <= OWN_ADDRESS_DATA;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            mask <= `ISG_MASK_RST;
        end else if (ADDRESS_MASK_WR) begin
            mask <= ADDRESS_MASK_DATA;
        end
    end
    // ****************************************************
    // Stretch-release control and address update
    // ****************************************************
    // Hardware clears win over a software set in the same cycle, so a
    // hold point is never missed.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            stretch_release_ctl <= 1'b1;
        end else if (!PORT_ENABLE) begin
            stretch_release_ctl <= 1'b1;
        end else if (hw_clr) begin
            stretch_release_ctl <= 1'b0;
        end else if (STRETCH_RELEASE_SET) begin
            stretch_release_ctl <= 1'b1;
        end else if (STRETCH_RELEASE_CLEAR) begin
            stretch_release_ctl <= 1'b0;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ua <= 1'b0;
        end else if (ua_set) begin
            ua <= 1'b1;
        end else if (OWN_ADDRESS_WR || !tgt) begin
            ua <= 1'b0;
        end
    end
    // ****************************************************
    // Line drivers
    // ****************************************************
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            scl_low <= 1'b0;
        end else if (fw) begin
            scl_low <= FW_SCL_LOW;
        end else if (!tgt) begin
            scl_low <= 1'b0;
        end else begin
            scl_low <= (scl_low || !scl_s) && (!stretch_release_ctl || ua);
        end
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            sda_low <= 1'b0;
        end else if (fw) begin
            sda_low <= FW_SDA_LOW;
        end else if (!tgt || ev.stop || ev.start) begin
            sda_low <= 1'b0;
        end else if (!scl_s && !ev.fall) begin
            // Data only changes while SCL is low
            if (bit_cnt == `ISG_BIT_ACK && ((state == isg_pkg::ST_ADDR
                && addr_hit) || state == isg_pkg::ST_RX)) begin
                sda_low <= ack_hold ? !ACK_VALUE_TO_SEND : 1'b1;
            end else if (state == isg_pkg::ST_TX
                && bit_cnt < `ISG_BIT_ACK) begin
                sda_low <= !tx_bit;
            end else begin
                sda_low <= 1'b0;
            end
        end
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            pin_level <= 1'b0;
        end else begin
            pin_level <= 1'b0;
        end
    end
    // ****************************************************
    // Transfer buffer and flags
    // ****************************************************
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            buffer <= 8'h00;
        end else if (byte_ev) begin
            buffer <= rx_byte;
        end else if (BUF_WR && !write_collision_flag_hit) begin
            buffer <= BUF_WDATA;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            bf <= 1'b0;
        end else if (byte_ev || (BUF_WR && !write_collision_flag_hit)) begin
            bf <= 1'b1;
        end else if (BUF_RD || (fall8 && state == isg_pkg::ST_TX)) begin
            bf <= 1'b0;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            write_collision_flag <= 1'b0;
        end else if (write_collision_flag_hit) begin
            write_collision_flag <= 1'b1;
        end else if (WRITE_COLLISION_FLAG_CLEAR) begin
            write_collision_flag <= 1'b0;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            irq <= 1'b0;
        end else if (irq_ev) begin
            irq <= 1'b1;
        end else if (IRQ_CLEAR) begin
            irq <= 1'b0;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            req_d <= 3'h0;
        end else begin
            req_d <= {START_REQUEST, STOP_REQUEST, RESTART_REQUEST};
        end
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ack_stat <= 1'b0;
        end else if (fall9 && state == isg_pkg::ST_TX) begin
            ack_stat <= link_shift[0];
        end
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            s_flag <= 1'b0;
            p_flag <= 1'b0;
        end else if (!PORT_ENABLE) begin
            s_flag <= 1'b0;
            p_flag <= 1'b0;
        end else if (ev.start) begin
            s_flag <= 1'b1;
            p_flag <= 1'b0;
        end else if (ev.stop) begin
            s_flag <= 1'b0;
            p_flag <= 1'b1;
        end
    end
    // ****************************************************
    // Outputs
    // ****************************************************
    assign SCL_OUT = pin_level;
    assign SDA_OUT = pin_level;
    assign SCL_OE = scl_low;
    assign SDA_OE = sda_low;
    assign STRETCH_RELEASE_CTL = stretch_release_ctl;
    assign ADDRESS_UPDATE_FLAG = ua;
    assign BUFFER_FULL_FLAG = bf;
    assign SERIAL_PORT_IRQ_FLAG = irq;
    assign WRITE_COLLISION_FLAG = write_collision_flag;
    assign TRANSFER_BUFFER = buffer;
    assign ACK_STATUS = ack_stat;
    assign READ_NOT_WRITE = addr_rw;
    assign START_SEEN = s_flag;
    assign STOP_SEEN = p_flag;
    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);
    a_scl_no_pull_high: assert property (
        $rose(scl_low) && !fw |-> $past(!scl_s))
        else $error("SCL pulled low while seen high");
    a_scl_let_go: assert property (
        tgt && stretch_release_ctl && !ua |=> !scl_low)
        else $error("SCL still held after release");
    a_read_clears: assert property (
        fall9 && tgt && state == isg_pkg::ST_TX && !link_shift[0]
        |=> !stretch_release_ctl)
        else $error("Read ack did not clear stretch-release");
    a_sen_stretch: assert property (
        fall9 && tgt && state == isg_pkg::ST_RX && !link_shift[0]
        && STRETCH_ENABLE |=> !stretch_release_ctl ##1 (scl_low || scl_s))
        else $error("No stretch after ack with stretch enable");
    a_ua_hold: assert property (
        tgt && ua && !scl_s |=> scl_low)
        else $error("Address update did not stretch SCL");
    a_ua_release: assert property (
        OWN_ADDRESS_WR && !ua_set |=> !ua ##1 (!scl_low || !stretch_release_ctl))
        else $error("Own address write did not release SCL");
    a_addr_hold: assert property (
        fall8 && tgt && state == isg_pkg::ST_ADDR && addr_ok
        && ADDRESS_HOLD_ENABLE |=> !stretch_release_ctl && irq)
        else $error("Address hold did not clear stretch-release");
    a_data_hold: assert property (
        fall8 && tgt && state == isg_pkg::ST_RX && DATA_HOLD_ENABLE
        |=> !stretch_release_ctl && bf)
        else $error("Data hold did not clear stretch-release");
    a_gcall_ack: assert property (
        fall8 && tgt && state == isg_pkg::ST_ADDR && GENERAL_CALL_ENABLE
        && rx_byte == 8'h00 && !ten_lo |=> addr_hit && addr_gc)
        else $error("General call not accepted");
    a_write_collision_flag_drop: assert property (
        BUF_WR && ctl && START_REQUEST && !byte_ev
        |=> write_collision_flag && buffer == $past(buffer))
        else $error("Queued buffer write not refused");
    a_req_done_irq: assert property (
        ctl && $fell(STOP_REQUEST) |=> irq)
        else $error("No interrupt on request completion");
    c_addr_hold: cover property (hold8 ##[1:200] STRETCH_RELEASE_SET);
    c_read_go: cover property (tx_go && state == isg_pkg::ST_ADDR);
    c_ten_ua: cover property (ua_set ##[1:400] OWN_ADDRESS_WR);
    c_gcall: cover property (fall8 && gcall);
endmodule : isg_target
`default_nettype wire

/* rtl/isg_consts.svh */
// Constants for the I2C target engine with stretch, general call and mask
`ifndef ISG_CONSTS_SVH
`define ISG_CONSTS_SVH
// ****************************************************
// Port mode select codes
// ****************************************************
`define ISG_MODE_TGT7 4'h6
`define ISG_MODE_TGT10 4'h7
`define ISG_MODE_CTRL 4'h8
`define ISG_MODE_FWCTRL 4'hB
// ****************************************************
// Address matching
// ****************************************************
`define ISG_MASK_RST 8'hFF
`define ISG_OWN_RST 8'h00
`define ISG_GCALL_ADDR 8'h00
`define ISG_TEN_PFX 5'h1E
// ****************************************************
// Bit counter positions within a byte frame
// ****************************************************
`define ISG_BIT_ACK 4'h8
`define ISG_BIT_END 4'h9
`endif

/* rtl/isg_pkg.sv */
// Types shared by the I2C target engine
package isg_pkg;
    // ****************************************************
    // Target protocol states
    // ****************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_RX = 3'b010,
        ST_TX = 3'b011,
        ST_SKIP = 3'b100
    } isg_state_t;
    // ****************************************************
    // Bus events seen on the synchronised lines
    // ****************************************************
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } isg_ev_t;
endpackage : isg_pkg

/* dv/isg_bus_model.sv */
// Behavioural I2C controller on the far side of the target engine
`timescale 1ns/100ps
`default_nettype none
module isg_bus_model (
    input wire logic scl,
    input wire logic sda,
    output logic scl_oe,
    output logic sda_oe
);
    initial begin
        scl_oe = 1'h0;
        sda_oe = 1'h0;
    end
    // Low 40 ns, high 24 ns; a stretch only lengthens the low phase
    task automatic bit_cyc(input logic b, output logic s);
        #20 sda_oe = ~b;
        #20 scl_oe = 1'h0;
        for (int i = 0; i < 9000 && scl !== 1'h1; i++) #4;
        #24 s = sda;
        scl_oe = 1'h1;
    endtask : bit_cyc
    task automatic start_c();
        #40 sda_oe = 1'h1;
        #40 scl_oe = 1'h1;
    endtask : start_c
    task automatic stop_c();
        #20 sda_oe = 1'h1;
        #20 scl_oe = 1'h0;
        #40 sda_oe = 1'h0;
        #40;
    endtask : stop_c
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
        bit_cyc(1'h1, ack);
    endtask : put
    task automatic get(output logic [7:0] d, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cyc(1'h1, d[i]);
        bit_cyc(nack, s);
    endtask : get
endmodule : isg_bus_model
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the I2C target engine
`include "isg_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic [3:0] mode = `ISG_MODE_TGT7;
    logic sten = 1'h0, address_hold_enable = 1'h0, general_call_enable = 1'h0, ackv = 1'h1, req = 1'h0;
    logic fw = 1'h0;
    logic [4:0] stb = 5'h00;
    logic [7:0] wd = 8'h00;
    logic m_scl, m_sda, scl_oe, sda_oe, scl_out, sda_out, rel, irq, write_collision_flag;
    logic ua_f, bff, ackst, rnw, ss, ps;
    logic [7:0] tbuf;
    int err_total = 0;
    int total_checks = 0;
    wire logic scl_w = ~(m_scl | scl_oe);
    wire logic sda_w = ~(m_sda | sda_oe);
    always #2.5 clk = ~clk;
    isg_bus_model mdl (.scl(scl_w), .sda(sda_w), .scl_oe(m_scl),
        .sda_oe(m_sda));
    isg_target dut (.CLK_SYS(clk), .RSTN(rstn), .SCL_LINK(scl_w),
        .SCL_IN(scl_w), .SDA_IN(sda_w), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .PORT_ENABLE(1'h1),
        .PORT_MODE_SELECT(mode), .STRETCH_ENABLE(sten),
        .ADDRESS_HOLD_ENABLE(address_hold_enable), .DATA_HOLD_ENABLE(1'h0),
        .GENERAL_CALL_ENABLE(general_call_enable), .ACK_VALUE_TO_SEND(ackv),
        .OWN_ADDRESS_WR(stb[0]), .OWN_ADDRESS_DATA(wd),
        .ADDRESS_MASK_WR(stb[1]), .ADDRESS_MASK_DATA(wd),
        .STRETCH_RELEASE_SET(stb[2]), .STRETCH_RELEASE_CLEAR(1'h0),
        .BUF_WR(stb[3]), .BUF_WDATA(wd), .BUF_RD(1'h0), .IRQ_CLEAR(stb[4]),
        .WRITE_COLLISION_FLAG_CLEAR(1'h0), .START_REQUEST(req), .STOP_REQUEST(req),
        .RESTART_REQUEST(req), .FW_SCL_LOW(fw), .FW_SDA_LOW(fw),
        .STRETCH_RELEASE_CTL(rel), .ADDRESS_UPDATE_FLAG(ua_f),
        .BUFFER_FULL_FLAG(bff), .SERIAL_PORT_IRQ_FLAG(irq),
        .WRITE_COLLISION_FLAG(write_collision_flag), .TRANSFER_BUFFER(tbuf),
        .ACK_STATUS(ackst), .READ_NOT_WRITE(rnw), .START_SEEN(ss),
        .STOP_SEEN(ps));
    task automatic chk(input logic [7:0] e, s, input string n);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask : tk
    // Strobes: 0 own address, 1 mask, 2 release, 3 buffer, 4 irq clear
    task automatic pls(input int k);
        @(posedge clk) stb <= 5'h01 << k;
        @(posedge clk) stb <= 5'h00;
    endtask : pls
    task automatic wrel(input logic v);
        int i;
        for (i = 0; i < 4000 && rel !== v; i++) @(posedge clk);
        if (i == 4000) begin
            chk(v, rel, "release_wait");
            final_report();
        end
        tk(2);
    endtask : wrel
    task automatic t_mask();
        logic a;
        wd <= 8'hA0;
        pls(0);
        mdl.start_c();
        chk(1'h1, ss, "start_seen");
        mdl.put(8'hA2, a);
        chk(1'h1, a, "ack_mask_reset");
        mdl.stop_c();
        chk(1'h1, ps, "stop_seen");
        wd <= 8'hFD;
        pls(1);
        mdl.start_c();
        mdl.put(8'hA2, a);
        chk(1'h0, a, "ack_masked");
        mdl.stop_c();
        $display("test mask done");
    endtask : t_mask
    task automatic t_read();
        logic a;
        logic [7:0] d;
        general_call_enable <= 1'h1;
        pls(4);
        mdl.start_c();
        mdl.put(8'h00, a);
        tk(8);
        chk(1'h0, a, "ack_gcall");
        chk(1'h1, irq, "irq_gcall");
        chk(8'h00, tbuf, "buffer_gcall");
        chk(1'h1, bff, "full_gcall");
        mdl.stop_c();
        mdl.start_c();
        mdl.put(8'hA1, a);
        tk(8);
        chk(1'h0, rel, "release_read");
        chk(1'h1, scl_oe, "scl_hold_read");
        chk(1'h1, rnw, "read_flag");
        wd <= 8'h5A;
        pls(3);
        pls(2);
        mdl.get(d, 1'h1);
        chk(8'h5A, d, "read_byte");
        tk(8);
        chk(1'h1, ackst, "ack_status");
        mdl.stop_c();
        $display("test read done");
    endtask : t_read
    task automatic t_hold();
        logic a;
        {sten, address_hold_enable, ackv} <= 3'h6;
        for (int k = 0; k < 2; k++) begin
            mdl.start_c();
            fork
                mdl.put(k == 0 ? 8'hA0 : 8'h00, a);
                begin
                    wrel(1'h0);
                    chk(1'h1, scl_oe, "scl_hold_addr");
                    pls(2);
                end
            join
            chk(1'h0, a, "ack_hold");
            wrel(1'h0);
            chk(1'h1, scl_oe, "scl_hold_ack");
            pls(2);
            tk(4);
            mdl.stop_c();
        end
        $display("test hold done");
    endtask : t_hold
    task automatic t_ten();
        logic a;
        {sten, address_hold_enable} <= 2'h0;
        mode <= `ISG_MODE_TGT10;
        wd <= 8'h06;
        pls(0);
        mdl.start_c();
        mdl.put(8'hF6, a);
        tk(8);
        chk(1'h0, a, "ack_ten_high");
        chk(1'h1, ua_f, "ua_high");
        chk(1'h1, scl_oe, "scl_hold_ua");
        wd <= 8'h55;
        pls(0);
        tk(2);
        chk(1'h0, scl_oe, "scl_free_ua");
        mdl.put(8'h57, a);
        tk(8);
        chk(1'h0, a, "ack_ten_low");
        wd <= 8'h06;
        pls(0);
        tk(2);
        chk(1'h0, ua_f, "ua_low");
        mdl.stop_c();
        $display("test ten done");
    endtask : t_ten
    task automatic t_ctrl();
        mode <= `ISG_MODE_CTRL;
        req <= 1'h1;
        pls(3);
        tk(2);
        chk(1'h1, write_collision_flag, "write_collision_flag");
        pls(4);
        req <= 1'h0;
        tk(3);
        chk(1'h1, irq, "irq_done");
        mode <= `ISG_MODE_FWCTRL;
        fw <= 1'h1;
        tk(3);
        chk(1'h1, scl_oe & sda_oe, "fw_pull");
        chk(1'h0, scl_out | sda_out, "drive_high");
        $display("test controller done");
    endtask : t_ctrl
    initial begin
        tk(12);
        rstn <= 1'h1;
        tk(4);
        chk(1'h0, scl_oe, "scl_rst");
        t_mask();
        t_read();
        t_hold();
        t_ten();
        t_ctrl();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
